/* File: hdl/nvm_pkg.sv */
// Purpose: shared constants for the byte program controller and its core-side end
// Assumes: 200 MHz system clock, calibrated oscillator arrives as a pin
// Notes:   counts of oscillator ticks are derived from the times below
`default_nettype none
package nvm_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH  = 512;
  localparam int unsigned TICK_W = 16;

  // device register selects on the link
  localparam logic [1:0] SEL_ADDR_LOW  = 2'h0;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h1;
  localparam logic [1:0] SEL_DATA      = 2'h2;
  localparam logic [1:0] SEL_CTRL      = 2'h3;

  // control register field positions
  localparam int unsigned CTRL_READ_BIT = 0;
  localparam int unsigned CTRL_PROG_BIT = 1;
  localparam int unsigned CTRL_MPE_BIT  = 2;
  localparam int unsigned CTRL_MODE_LSB = 4;

  // programming modes
  localparam logic [1:0] MODE_ATOMIC     = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
  localparam logic [1:0] MODE_RESERVED   = 2'h3;

  // reset values and cycle counts
  localparam logic [1:0]        MODE_RESET        = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET        = 8'h00;
  localparam logic [DATA_W-1:0] ERASED_VALUE      = 8'hFF;
  localparam logic [2:0]        MPE_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0]        READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0]        PROG_STALL_CYCLES = 3'h2;

  // programming times, timed in ticks of the calibrated oscillator
  localparam int unsigned OSC_KHZ            = 8000;
  localparam int unsigned ATOMIC_PHASE_US    = 1700;
  localparam int unsigned SPLIT_US           = 1800;
  localparam int unsigned ATOMIC_PHASE_TICKS = ATOMIC_PHASE_US * OSC_KHZ / 1000;
  localparam int unsigned SPLIT_TICKS        = SPLIT_US * OSC_KHZ / 1000;

  // core-side Avalon register map (byte addresses)
  localparam int unsigned AV_ADDR_W   = 5;
  localparam logic [4:0]  OFS_CMD     = 5'h00;
  localparam logic [4:0]  OFS_ADDR    = 5'h04;
  localparam logic [4:0]  OFS_DATA    = 5'h08;
  localparam logic [4:0]  OFS_MODE    = 5'h0C;
  localparam logic [4:0]  OFS_STATUS  = 5'h10;
  localparam int unsigned CMD_READ_BIT    = 0;
  localparam int unsigned CMD_PROG_BIT    = 1;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_READY_BIT  = 2;
endpackage
`default_nettype wire

/* File: hdl/nvm_link_if.sv */
// Purpose: register link between the processor-side end and the byte program controller
// Assumes: both ends on the same clock
// Notes:   wr and rd are one-cycle strobes; rdata is valid the cycle after rd
`default_nettype none
interface nvm_link_if;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       stall;
  logic       ready;

  modport device (input sel, input wdata, input wr, input rd, output rdata, output stall, output ready);
  modport core   (output sel, output wdata, output wr, output rd, input rdata, input stall, input ready);
endinterface
`default_nettype wire

/* File: hdl/nvm_byte_ctrl.sv */
// Purpose: byte read and program control for the on-chip data array
// Assumes: processor end honours stall and keeps the documented sequences
// Notes:   programming engine runs on power_resetn so a system reset lets it finish
//
// Overview of operation
// - software loads address and data before programming
// - mode zero plus enabled strobe: erase then write
// - strobe stays set through both atomic phases
// - mode one plus enabled strobe: erase only
// - strobe stays set until erase completes
// - mode two plus enabled strobe: write only
// - strobe stays set until write completes
// - software erases before write-only programming
// - array refuses all access while programming
// - programming timed by calibrated oscillator ticks
// - system reset does not abort running programming
// - program: poll, mode, address, data, enable, strobe
// - read: poll, address, read strobe, take data
// - master enable self-clears after four cycles
// - mode locked while busy; reset clears otherwise
// - mode three reserved, others select operation
// - read fetches at once, stalls four cycles
`default_nettype none
module nvm_byte_ctrl #(
  parameter int unsigned ATOMIC_TICKS = nvm_pkg::ATOMIC_PHASE_TICKS,
  parameter int unsigned SPLIT_TICKS  = nvm_pkg::SPLIT_TICKS
) (
  input  wire logic   clock,
  input  wire logic   resetn,
  input  wire logic   power_resetn,
  input  wire logic   osc_pin,
  input  wire logic   supply_ok_pin,
  nvm_link_if.device  link
);
  import nvm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} eng_state_e;

  localparam logic [TICK_W-1:0] ATOMIC_LAST = TICK_W'(ATOMIC_TICKS - 1);
  localparam logic [TICK_W-1:0] SPLIT_LAST  = TICK_W'(SPLIT_TICKS - 1);

  logic              osc_meta;
  logic              osc_sync;
  logic              osc_prev;
  logic              sup_meta;
  logic              sup_ok;
  logic              tick;
  eng_state_e        state;
  logic [TICK_W-1:0] tick_count;
  logic [ADDR_W-1:0] eng_addr;
  logic [DATA_W-1:0] eng_data;
  logic [1:0]        eng_mode;
  logic [ADDR_W-1:0] byte_addr_reg;
  logic [DATA_W-1:0] byte_data_reg;
  logic [1:0]        mode_reg;
  logic [2:0]        mpe_count;
  logic [2:0]        stall_count;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] array [DEPTH];
  logic              busy;
  logic              stall;
  logic              mpe_active;
  logic              wr_ok;
  logic              ctrl_wr;
  logic [1:0]        wr_mode;
  logic              start;
  logic              read_go;
  logic              phase_end;
  logic [1:0]        vis_mode;

  // pin synchronisers; logic takes the second stage, and the oscillator edge detect also takes a third
  always_ff @(posedge clock or negedge power_resetn) begin
    if (!power_resetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      sup_meta <= 1'b0;
      sup_ok   <= 1'b0;
    end else begin
      osc_meta <= osc_pin;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      sup_meta <= supply_ok_pin;
      sup_ok   <= sup_meta;
    end
  end

  // one tick per rising oscillator edge
  assign tick = osc_sync & ~osc_prev;

  // request decode; refused requests during stall simply vanish
  assign busy       = (state != ST_IDLE);
  assign stall      = (stall_count != 3'h0);
  assign mpe_active = (mpe_count != 3'h0);
  assign wr_ok      = link.wr & ~stall;
  assign ctrl_wr    = wr_ok & (link.sel == SEL_CTRL);
  assign wr_mode    = link.wdata[CTRL_MODE_LSB +: 2];
  // reserved mode never starts a program
  assign start      = ctrl_wr & link.wdata[CTRL_PROG_BIT] & mpe_active & ~busy
                      & (wr_mode != MODE_RESERVED);
  assign read_go    = ctrl_wr & link.wdata[CTRL_READ_BIT] & ~busy & ~start;
  assign phase_end  = tick & (tick_count == '0);

  // programming engine: survives system reset, aborts on low supply or power reset
  always_ff @(posedge clock or negedge power_resetn) begin
    if (!power_resetn) begin
      state      <= ST_IDLE;
      tick_count <= '0;
      eng_addr   <= '0;
      eng_data   <= DATA_RESET;
      eng_mode   <= MODE_RESET;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            eng_addr <= byte_addr_reg;
            eng_data <= byte_data_reg;
            eng_mode <= wr_mode;
            if (wr_mode == MODE_WRITE_ONLY) begin
              state      <= ST_WRITE;
              tick_count <= SPLIT_LAST;
            end else begin
              state      <= ST_ERASE;
              tick_count <= (wr_mode == MODE_ATOMIC) ? ATOMIC_LAST : SPLIT_LAST;
            end
          end
        end
        ST_ERASE: begin
          if (!sup_ok) begin
            state <= ST_IDLE;
          end else if (phase_end) begin
            if (eng_mode == MODE_ATOMIC) begin
              state      <= ST_WRITE;
              tick_count <= ATOMIC_LAST;
            end else begin
              state <= ST_IDLE;
            end
          end else if (tick) begin
            tick_count <= tick_count - 1'b1;
          end
        end
        ST_WRITE: begin
          if (!sup_ok || phase_end) begin
            state <= ST_IDLE;
          end else if (tick) begin
            tick_count <= tick_count - 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // array storage; write-only over unerased bits keeps only common ones
  always_ff @(posedge clock) begin
    if (sup_ok && phase_end) begin
      if (state == ST_ERASE) begin
        array[eng_addr] <= ERASED_VALUE;
      end else if (state == ST_WRITE) begin
        array[eng_addr] <= array[eng_addr] & eng_data;
      end
    end
  end

  // address register, frozen while programming
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_addr_reg <= '0;
    end else if (wr_ok && !busy) begin
      if (link.sel == SEL_ADDR_LOW) begin
        byte_addr_reg[7:0] <= link.wdata;
      end else if (link.sel == SEL_ADDR_HIGH) begin
        byte_addr_reg[8] <= link.wdata[0];
      end
    end
  end

  // data register: loaded by software or by a read fetch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      byte_data_reg <= DATA_RESET;
    end else if (read_go) begin
      byte_data_reg <= array[byte_addr_reg];
    end else if (wr_ok && !busy && link.sel == SEL_DATA) begin
      byte_data_reg <= link.wdata;
    end
  end

  // mode field ignores writes while the strobe is set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_RESET;
    end else if (ctrl_wr && !busy) begin
      mode_reg <= wr_mode;
    end
  end

  // a reset during programming must not hide the running mode
  assign vis_mode = busy ? eng_mode : mode_reg;

  // master enable window, reloads on every enable write that does not start a program
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mpe_count <= 3'h0;
    end else if (ctrl_wr && link.wdata[CTRL_MPE_BIT] && !start) begin
      mpe_count <= MPE_WINDOW_CYCLES;
    end else if (start) begin
      mpe_count <= 3'h0;
    end else if (mpe_active) begin
      mpe_count <= mpe_count - 3'h1;
    end
  end

  // processor halt after read or program start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stall_count <= 3'h0;
    end else if (read_go) begin
      stall_count <= READ_STALL_CYCLES;
    end else if (start) begin
      stall_count <= PROG_STALL_CYCLES;
    end else if (stall) begin
      stall_count <= stall_count - 3'h1;
    end
  end

  // registered read-back, valid the cycle after rd
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= DATA_RESET;
    end else if (link.rd && !stall) begin
      case (link.sel)
        SEL_ADDR_LOW:  rdata_q <= byte_addr_reg[7:0];
        SEL_ADDR_HIGH: rdata_q <= {7'h00, byte_addr_reg[8]};
        SEL_DATA:      rdata_q <= byte_data_reg;
        SEL_CTRL:      rdata_q <= {2'b00, vis_mode, 1'b0, mpe_active, busy, 1'b0};
        default:       rdata_q <= DATA_RESET;
      endcase
    end
  end

  assign link.rdata = rdata_q;
  assign link.stall = stall;
  assign link.ready = ~busy;
endmodule
`default_nettype wire

/* File: hdl/nvm_core_ctrl.sv */
// Purpose: processor-side end that runs read and program sequences on the link
// Assumes: software commands arrive over Avalon-MM
// Notes:   one link access every other cycle so stall is always seen in time
`default_nettype none
module nvm_core_ctrl (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [nvm_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  nvm_link_if.core                         link
);
  import nvm_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE, C_POLL, C_CHECK, C_MODE, C_ADDR_LO, C_ADDR_HI,
    C_DATA, C_ENABLE, C_STROBE, C_READ, C_FETCH, C_TAKE
  } core_state_e;

  core_state_e       state;
  logic              op_program;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic [1:0]        cmd_mode;
  logic [DATA_W-1:0] read_result;
  logic              done;
  logic              resp_q;
  logic [31:0]       rdata_q;
  logic              wr_q;
  logic              rd_q;
  logic [1:0]        sel_q;
  logic [7:0]        wdata_q;
  logic              can_issue;
  logic              av_wr;
  logic              busy;
  logic              finish;
  logic [7:0]        ctrl_byte;

  // second cycle of each access answers; waitrequest high otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= (avs_read | avs_write) & ~resp_q;
    end
  end

  assign avs_waitrequest = ~resp_q;
  assign av_wr           = avs_write & resp_q;
  assign busy            = (state != C_IDLE);

  // read data prepared in the first cycle, standing at the answer edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read && !resp_q) begin
      case (avs_address)
        OFS_ADDR:   rdata_q <= {23'h000000, cmd_addr};
        OFS_DATA:   rdata_q <= {24'h000000, read_result};
        OFS_MODE:   rdata_q <= {30'h00000000, cmd_mode};
        OFS_STATUS: rdata_q <= {29'h00000000, link.ready, done, busy};
        default:    rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  // command parameters, held steady while a sequence runs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_addr <= '0;
      cmd_data <= DATA_RESET;
      cmd_mode <= MODE_RESET;
    end else if (av_wr && !busy) begin
      if (avs_address == OFS_ADDR) begin
        cmd_addr <= avs_writedata[ADDR_W-1:0];
      end else if (avs_address == OFS_DATA) begin
        cmd_data <= avs_writedata[DATA_W-1:0];
      end else if (avs_address == OFS_MODE) begin
        cmd_mode <= avs_writedata[1:0];
      end
    end
  end

  // done flag: a finish in the clearing cycle wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (av_wr && avs_address == OFS_STATUS && avs_writedata[STAT_DONE_BIT]) begin
      done <= 1'b0;
    end
  end

  // issue only after the previous strobe has gone and stall is clear
  assign can_issue = ~wr_q & ~rd_q & ~link.stall;
  assign finish    = can_issue & ((state == C_STROBE) | (state == C_TAKE));
  assign ctrl_byte = {2'b00, cmd_mode, 4'h0};

  // sequence engine; every link request is a registered one-cycle strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state       <= C_IDLE;
      op_program  <= 1'b0;
      read_result <= DATA_RESET;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      sel_q       <= SEL_CTRL;
      wdata_q     <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state)
        C_IDLE: begin
          if (av_wr && avs_address == OFS_CMD) begin
            if (avs_writedata[CMD_PROG_BIT]) begin
              op_program <= 1'b1;
              state      <= C_POLL;
            end else if (avs_writedata[CMD_READ_BIT]) begin
              op_program <= 1'b0;
              state      <= C_POLL;
            end
          end
        end
        C_POLL: begin
          if (can_issue) begin
            rd_q  <= 1'b1;
            sel_q <= SEL_CTRL;
            state <= C_CHECK;
          end
        end
        C_CHECK: begin
          if (can_issue) begin
            if (link.rdata[CTRL_PROG_BIT]) begin
              state <= C_POLL;
            end else begin
              state <= op_program ? C_MODE : C_ADDR_LO;
            end
          end
        end
        C_MODE: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_CTRL;
            wdata_q <= ctrl_byte;
            state   <= C_ADDR_LO;
          end
        end
        C_ADDR_LO: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_ADDR_LOW;
            wdata_q <= cmd_addr[7:0];
            state   <= C_ADDR_HI;
          end
        end
        C_ADDR_HI: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_ADDR_HIGH;
            wdata_q <= {7'h00, cmd_addr[8]};
            state   <= op_program ? C_DATA : C_READ;
          end
        end
        C_DATA: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_DATA;
            wdata_q <= cmd_data;
            state   <= C_ENABLE;
          end
        end
        C_ENABLE: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_CTRL;
            wdata_q <= ctrl_byte | (8'h01 << CTRL_MPE_BIT);
            state   <= C_STROBE;
          end
        end
        C_STROBE: begin
          // lands two cycles after the enable, inside its window
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_CTRL;
            wdata_q <= ctrl_byte | (8'h01 << CTRL_MPE_BIT) | (8'h01 << CTRL_PROG_BIT);
            state   <= C_IDLE;
          end
        end
        C_READ: begin
          if (can_issue) begin
            wr_q    <= 1'b1;
            sel_q   <= SEL_CTRL;
            wdata_q <= ctrl_byte | (8'h01 << CTRL_READ_BIT);
            state   <= C_FETCH;
          end
        end
        C_FETCH: begin
          if (can_issue) begin
            rd_q  <= 1'b1;
            sel_q <= SEL_DATA;
            state <= C_TAKE;
          end
        end
        C_TAKE: begin
          if (can_issue) begin
            read_result <= link.rdata;
            state       <= C_IDLE;
          end
        end
        default: state <= C_IDLE;
      endcase
    end
  end

  assign link.wr    = wr_q;
  assign link.rd    = rd_q;
  assign link.sel   = sel_q;
  assign link.wdata = wdata_q;
endmodule
`default_nettype wire

/* File: tb/nvm_link_assertions.sv */
// Purpose: link checks between the core end and the byte controller
// Assumes: one clock, resetn low clears the register side
// Notes:   ready low means a program runs
`default_nettype none
module nvm_link_assertions (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       stall,
  input wire logic       ready
);
  import nvm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // control accesses the device actually takes
  wire cw = wr && !stall && sel == SEL_CTRL;
  wire cr = rd && !stall && sel == SEL_CTRL;
  // read strobe write, then the four-cycle halt
  sequence s_rd_go;
    cw && wdata[CTRL_READ_BIT] && !wdata[CTRL_PROG_BIT] && ready;
  endsequence
  sequence s_halt4;
    stall[*4] ##1 !stall;
  endsequence
  property p_gap; (wr || rd) |=> !(wr || rd); endproperty
  a_gap: assert property (p_gap) else $error("link strobes back to back");
  property p_nostall; stall |-> !(wr || rd); endproperty
  a_nostall: assert property (p_nostall) else $error("request issued during halt");
  property p_rd_halt; s_rd_go |=> s_halt4; endproperty
  a_rd_halt: assert property (p_rd_halt) else $error("read halt not four cycles");
  property p_prog_start; $fell(ready) |-> stall; endproperty
  a_prog_start: assert property (p_prog_start) else $error("program began without halt");
  // even the shortest program spans several slow ticks
  property p_prog_hold; $fell(ready) |-> !ready[*8]; endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program ended too soon");
  property p_ctrl_rd;
    cr |=> rdata[CTRL_PROG_BIT] == !$past(ready) && rdata[CTRL_READ_BIT] == 1'b0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  property p_mode3;
    cw && wdata[CTRL_PROG_BIT] && wdata[5:4] == MODE_RESERVED && ready |=> ready[*3];
  endproperty
  a_mode3: assert property (p_mode3) else $error("reserved mode started a program");
  property p_rdata; !rd |=> $stable(rdata); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule
`default_nettype wire

/* File: tb/eeprom_byte_program_control_tb_top.sv */
// Purpose: end-to-end checks of core end and byte controller
// Assumes: short tick counts, oscillator pin ten clocks a period
// Notes:   expected bytes come from a local array model
`default_nettype none
module eeprom_byte_program_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_pkg::*;
  localparam int AT = 4;
  localparam int ST = 6;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        power_resetn = 1'b0;
  logic        osc_pin = 1'b0;
  logic        osc_run = 1'b1;
  logic        supply_ok_pin = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] seed = 32'h237B19CE;
  logic [7:0]  mem [DEPTH];
  int          error_cnt = 0;
  int          samples_checked = 0;
  nvm_link_if link ();
  nvm_byte_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) nvm_byte_ctrl_inst (.clock(clock), .resetn(resetn),
    .power_resetn(power_resetn), .osc_pin(osc_pin), .supply_ok_pin(supply_ok_pin), .link(link));
  nvm_core_ctrl nvm_core_ctrl_inst (.clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  nvm_link_assertions nvm_link_assertions_inst (.clock(clock), .resetn(resetn), .sel(link.sel),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .stall(link.stall), .ready(link.ready));
  // system clock; slow oscillator pin toggles every fifth rising edge
  always #2.5 clock = ~clock;
  logic [3:0]  osc_div = 4'h0;
  always @(posedge clock) begin
    if (osc_run) begin
      osc_div <= (osc_div == 4'h4) ? 4'h0 : osc_div + 4'h1;
      if (osc_div == 4'h4) osc_pin <= ~osc_pin;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // stored byte after a program in mode m
  function automatic logic [7:0] expect_byte(logic [1:0] m, logic [7:0] old, logic [7:0] d);
    case (m)
      MODE_ATOMIC:     return d;
      MODE_ERASE_ONLY: return ERASED_VALUE;
      MODE_WRITE_ONLY: return old & d;
      default:         return old;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus cycle: hold until waitrequest is sampled low, take data and release at that edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic av_rd(input logic [4:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic poll(input int b);
    logic [31:0] q;
    do av_rd(OFS_STATUS, q); while (q[b] !== 1'b1);
  endtask
  // starts a program and returns while it runs
  task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    poll(STAT_READY_BIT);
    av_wr(OFS_MODE, {30'h0, m});
    av_wr(OFS_ADDR, {23'h0, a});
    av_wr(OFS_DATA, {24'h0, d});
    av_wr(OFS_CMD, 32'h2);
    poll(STAT_DONE_BIT);
    av_wr(OFS_STATUS, 32'h2);
    mem[a] = expect_byte(m, mem[a], d);
  endtask
  task automatic rdchk(input logic [8:0] a);
    logic [31:0] q;
    poll(STAT_READY_BIT);
    av_wr(OFS_ADDR, {23'h0, a});
    av_wr(OFS_CMD, 32'h1);
    poll(STAT_DONE_BIT);
    av_wr(OFS_STATUS, 32'h2);
    av_rd(OFS_DATA, q);
    chk(q, {24'h0, mem[a]});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cut a hang well past the expected run length
  initial begin
    #400us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] q;
    logic [8:0]  a;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    power_resetn <= 1'b1;
    av_rd(OFS_STATUS, q);
    chk(q, 32'h4);
    av_rd(OFS_MODE, q);
    chk(q, {30'h0, MODE_RESET});
    av_rd(5'h14, q);
    chk(q, 32'h0);
    $display("test reset done");
    // corners first, then random places and values
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'(rnd());
      prog(MODE_ATOMIC, a, 8'(rnd()));
      rdchk(a);
    end
    $display("test random done");
    // every mode code on one byte, then write-only onto unerased data
    for (int m = 0; m < 4; m++) begin
      prog(2'(m), 9'h0A5, 8'h3C);
      rdchk(9'h0A5);
    end
    prog(MODE_WRITE_ONLY, 9'h0A5, 8'h5A);
    rdchk(9'h0A5);
    $display("test modes done");
    prog(MODE_ATOMIC, 9'h011, 8'h96);
    av_wr(OFS_DATA, 32'h69);
    av_rd(OFS_STATUS, q);
    chk({31'h0, q[STAT_READY_BIT]}, 32'h0);
    rdchk(9'h011);
    $display("test busy done");
    // system reset must not abort a running program
    prog(MODE_ATOMIC, 9'h022, 8'hC3);
    resetn <= 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rdchk(9'h022);
    $display("test reset_mid done");
    // supply loss mid-erase leaves the byte as it was
    prog(MODE_ERASE_ONLY, 9'h022, 8'h00);
    mem[9'h022] = 8'hC3;
    av_rd(OFS_STATUS, q);
    av_rd(OFS_STATUS, q);
    supply_ok_pin <= 1'b0;
    poll(STAT_READY_BIT);
    supply_ok_pin <= 1'b1;
    rdchk(9'h022);
    $display("test supply done");
    // a stopped oscillator freezes the program
    osc_run <= 1'b0;
    prog(MODE_ERASE_ONLY, 9'h011, 8'h00);
    for (int i = 0; i < 40; i++) av_rd(OFS_STATUS, q);
    chk({31'h0, q[STAT_READY_BIT]}, 32'h0);
    osc_run <= 1'b1;
    rdchk(9'h011);
    $display("test osc done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
